// >>> pkg/page_mmu_defs.vh
// register offsets, reset values and widths of the memory extender
`ifndef PAGE_MMU_DEFS_VH
`define PAGE_MMU_DEFS_VH

// ----------------------------------------
// register byte offsets (one word each)
// ----------------------------------------
`define OFS_PAGE_SEL 4'h0
`define OFS_PTR_HI 4'h1
`define OFS_PTR_MID 4'h2
`define OFS_PTR_LO 4'h3
`define OFS_WORD_POSTINC 4'h4
`define OFS_BYTE_POSTINC 4'h5
`define OFS_LINEAR_DATA 4'h6
`define OFS_PTR_ADD 4'h7
`define OFS_CALL_CTRL 4'h8
`define OFS_STATUS 4'h9

// ----------------------------------------
// reset values and widths
// ----------------------------------------
`define PAGE_RESET 8'h02
`define PTR_W 17
`define PAGE_WIN_BASE 2'h2
`define MEM_WORDS 131072

`endif

// >>> rtl/ptr_adder.v
// linear pointer arithmetic: increment or signed byte add, modulo 2^17
`timescale 1ns/1ps
`default_nettype none
module ptr_adder (
    input wire [16:0] ptr_i,
    input wire [7:0] delta_i,
    output wire [16:0] sum_o
);
    // sign-extend the byte, drop carry beyond bit 16 so it wraps
    wire [16:0] ext;
    assign ext = {{9{delta_i[7]}}, delta_i};
    assign sum_o = ptr_i + ext;
endmodule // ptr_adder
`default_nettype wire

// >>> rtl/paged_linear_memory_extender.v
// paged window and linear pointer memory extender with wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "page_mmu_defs.vh"
module paged_linear_memory_extender (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // wishbone classic slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [7:0] dat_i,
    output reg [7:0] dat_o,
    output reg ack_o,
    // cpu address translation and call/return sequencer
    input wire [15:0] cpu_addr_i,
    input wire call_i,
    input wire rtc_i,
    input wire [7:0] call_page_i,
    input wire [15:0] call_target_i,
    input wire [15:0] ret_addr_i,
    input wire [7:0] stack_din_i,
    output reg [16:0] ext_addr_o,
    output reg win_hit_o,
    output reg [7:0] stack_dout_o,
    output reg stack_push_o,
    output reg stack_pop_o,
    output reg pc_load_o,
    output reg [15:0] pc_o,
    output reg irq_block_o,
    output reg busy_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam S_IDLE = 3'h0;
    localparam S_C_RLO = 3'h1;
    localparam S_C_RHI = 3'h2;
    localparam S_C_PG = 3'h3;
    localparam S_C_JMP = 3'h4;
    localparam S_R_PG = 3'h5;
    localparam S_R_LO = 3'h6;
    localparam S_R_HI = 3'h7;

    reg [7:0] mem [0:`MEM_WORDS-1];
    reg [7:0] program_page_select_r;
    reg [16:0] linear_pointer_r;
    reg [2:0] seq_r;
    reg [7:0] new_page_r;
    reg [15:0] target_r;
    reg [15:0] ret_r;
    reg [7:0] ret_lo_r;
    reg sticky_call_r;
    wire req;
    wire [16:0] ptr_sum;
    reg [7:0] delta;
    reg ptr_upd;
    reg [7:0] rd_data;

    assign req = cyc_i & stb_i & ~ack_o;

    // ----------------------------------------
    // pointer arithmetic
    // ----------------------------------------
    // one adder serves both increment and signed add
    always @* begin
        delta = 8'h00;
        ptr_upd = 1'b0;
        if (req) begin
            case (adr_i)
                `OFS_WORD_POSTINC, `OFS_BYTE_POSTINC: begin
                    delta = 8'h01;
                    ptr_upd = 1'b1;
                end
                `OFS_PTR_ADD: begin
                    delta = dat_i;
                    ptr_upd = we_i;
                end
                default: begin
                    delta = 8'h00;
                    ptr_upd = 1'b0;
                end
            endcase
        end
    end

    ptr_adder u_add (
        .ptr_i(linear_pointer_r),
        .delta_i(delta),
        .sum_o(ptr_sum)
    );

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // data ports read memory at the pointer; the page is never consulted
    always @* begin
        case (adr_i)
            `OFS_PAGE_SEL: rd_data = program_page_select_r;
            `OFS_PTR_HI: rd_data = {7'h00, linear_pointer_r[16]};
            `OFS_PTR_MID: rd_data = linear_pointer_r[15:8];
            `OFS_PTR_LO: rd_data = linear_pointer_r[7:0];
            `OFS_WORD_POSTINC, `OFS_BYTE_POSTINC, `OFS_LINEAR_DATA:
                rd_data = mem[linear_pointer_r];
            `OFS_STATUS: rd_data = {4'h0, sticky_call_r, seq_r};
            default: rd_data = 8'h00;
        endcase
    end

    // ----------------------------------------
    // memory writes through the pointer
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (ce_i && req && we_i) begin
            if (adr_i == `OFS_WORD_POSTINC || adr_i == `OFS_BYTE_POSTINC ||
                    adr_i == `OFS_LINEAR_DATA) begin
                mem[linear_pointer_r] <= dat_i;
            end
        end
    end

    // ----------------------------------------
    // bus slave, pointer and call-seen flag registers
    // ----------------------------------------
    // single-cycle ack; the sequencer owns the page while busy, so bus
    // writes to the page are dropped during call/return
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 8'h00;
            linear_pointer_r <= 17'h00000;
            sticky_call_r <= 1'b0;
        end else if (ce_i) begin
            ack_o <= req;
            if (req) begin
                dat_o <= we_i ? 8'h00 : rd_data;
                if (ptr_upd) begin
                    linear_pointer_r <= ptr_sum;
                end else if (we_i) begin
                    case (adr_i)
                        `OFS_PTR_HI: linear_pointer_r[16] <= dat_i[0];
                        `OFS_PTR_MID: linear_pointer_r[15:8] <= dat_i;
                        `OFS_PTR_LO: linear_pointer_r[7:0] <= dat_i;
                        // writing one clears the call-seen flag
                        `OFS_CALL_CTRL: sticky_call_r <= sticky_call_r &
                            ~dat_i[0];
                        default: linear_pointer_r <= linear_pointer_r;
                    endcase
                end
            end
            // set wins over clear
            if (call_i && seq_r == S_IDLE) begin
                sticky_call_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // call / return sequencer
    // ----------------------------------------
    // irq_block_o stays high for the whole sequence
    always @(posedge clk_i) begin
        if (rst_i) begin
            seq_r <= S_IDLE;
            program_page_select_r <= `PAGE_RESET;
            new_page_r <= 8'h00;
            target_r <= 16'h0000;
            ret_r <= 16'h0000;
            ret_lo_r <= 8'h00;
            stack_dout_o <= 8'h00;
            stack_push_o <= 1'b0;
            stack_pop_o <= 1'b0;
            pc_load_o <= 1'b0;
            pc_o <= 16'h0000;
            irq_block_o <= 1'b0;
            busy_o <= 1'b0;
        end else if (ce_i) begin
            stack_push_o <= 1'b0;
            stack_pop_o <= 1'b0;
            pc_load_o <= 1'b0;
            case (seq_r)
                S_IDLE: begin
                    if (call_i) begin
                        new_page_r <= call_page_i;
                        target_r <= call_target_i;
                        stack_dout_o <= ret_addr_i[7:0];
                        stack_push_o <= 1'b1;
                        ret_r <= ret_addr_i;
                        irq_block_o <= 1'b1;
                        busy_o <= 1'b1;
                        seq_r <= S_C_RLO;
                    end else if (rtc_i) begin
                        stack_pop_o <= 1'b1;
                        irq_block_o <= 1'b1;
                        busy_o <= 1'b1;
                        seq_r <= S_R_PG;
                    end else if (req && we_i && adr_i == `OFS_PAGE_SEL) begin
                        program_page_select_r <= dat_i;
                    end
                end
                S_C_RLO: begin
                    stack_dout_o <= ret_r[15:8];
                    stack_push_o <= 1'b1;
                    seq_r <= S_C_RHI;
                end
                S_C_RHI: begin
                    stack_dout_o <= program_page_select_r;
                    stack_push_o <= 1'b1;
                    seq_r <= S_C_PG;
                end
                S_C_PG: begin
                    program_page_select_r <= new_page_r;
                    seq_r <= S_C_JMP;
                end
                S_C_JMP: begin
                    pc_o <= target_r;
                    pc_load_o <= 1'b1;
                    irq_block_o <= 1'b0;
                    busy_o <= 1'b0;
                    seq_r <= S_IDLE;
                end
                S_R_PG: begin
                    // the stack must show the popped byte during the pop
                    // pulse itself; a late stack hands over stale data
                    program_page_select_r <= stack_din_i;
                    stack_pop_o <= 1'b1;
                    seq_r <= S_R_LO;
                end
                S_R_LO: begin
                    ret_lo_r <= stack_din_i;
                    stack_pop_o <= 1'b1;
                    seq_r <= S_R_HI;
                end
                S_R_HI: begin
                    pc_o <= {ret_lo_r, stack_din_i};
                    pc_load_o <= 1'b1;
                    irq_block_o <= 1'b0;
                    busy_o <= 1'b0;
                    seq_r <= S_IDLE;
                end
                default: seq_r <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // paging window translation
    // ----------------------------------------
    // outside the window the cpu address passes through with bit 16 clear,
    // so page one aliases the directly mapped block 0x4000-0x7FFF
    always @(posedge clk_i) begin
        if (rst_i) begin
            ext_addr_o <= 17'h00000;
            win_hit_o <= 1'b0;
        end else if (ce_i) begin
            if (cpu_addr_i[15:14] == `PAGE_WIN_BASE) begin
                ext_addr_o <= {program_page_select_r[2:0],
                    cpu_addr_i[13:0]};
                win_hit_o <= 1'b1;
            end else begin
                ext_addr_o <= {1'b0, cpu_addr_i};
                win_hit_o <= 1'b0;
            end
        end
    end
    // relies on software not writing the page from paged code
endmodule // paged_linear_memory_extender
`default_nettype wire

// >>> test/cpu_stack_model.sv
// processor-side stack model answering pushes and pops
`timescale 1ns/1ps
`default_nettype none
module cpu_stack_model (
    input wire logic clk_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [7:0] dout_i,
    output logic [7:0] din_o
);
    logic [7:0] mem_r [0:15];
    logic [3:0] sp_r = 4'h0;
    logic [7:0] top;
    // the extender samples the popped byte in the pop cycle itself; at
    // other times the inverse stands, so a mistimed sample reads wrong
    assign top = mem_r[sp_r - 4'h1];
    assign din_o = pop_i ? top : ~top;
    // last in first out
    always @(posedge clk_i) begin
        if (push_i) begin
            mem_r[sp_r] <= dout_i;
            sp_r <= sp_r + 4'h1;
        end
        if (pop_i) begin
            sp_r <= sp_r - 4'h1;
        end
    end
endmodule // cpu_stack_model
`default_nettype wire

// >>> test/mem_ext_checker.sv
// port assertions for the paged linear memory extender
`timescale 1ns/1ps
`default_nettype none
module mem_ext_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [15:0] cpu_addr_i,
    input wire logic [16:0] ext_addr_o,
    input wire logic win_hit_o,
    input wire logic call_i,
    input wire logic rtc_i,
    input wire logic busy_o,
    input wire logic [15:0] ret_addr_i,
    input wire logic [15:0] call_target_i,
    input wire logic [7:0] stack_dout_o,
    input wire logic stack_push_o,
    input wire logic stack_pop_o,
    input wire logic pc_load_o,
    input wire logic [15:0] pc_o,
    input wire logic irq_block_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // call start and its three pushes, low return byte first
    sequence s_call;
        call_i && !busy_o;
    endsequence
    sequence s_push3;
        (stack_push_o && stack_dout_o == $past(ret_addr_i[7:0]))
        ##1 (stack_push_o && stack_dout_o == $past(ret_addr_i[15:8], 2))
        ##1 stack_push_o;
    endsequence
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held");
    a_ack_answer: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack");
    a_win_decode: assert property (
        !$past(rst_i) |-> win_hit_o == ($past(cpu_addr_i[15:14]) == 2'h2))
        else $error("window decode");
    a_ext_direct: assert property (
        !$past(rst_i) && $past(cpu_addr_i[15:14]) != 2'h2 |->
        ext_addr_o == {1'b0, $past(cpu_addr_i)})
        else $error("direct address");
    a_call_push: assert property (s_call |=> s_push3)
        else $error("call pushes");
    a_call_jump: assert property (
        s_call |-> ##5 (pc_load_o && pc_o == $past(call_target_i, 5)))
        else $error("call jump");
    a_call_atomic: assert property (s_call |=> irq_block_o [*4])
        else $error("call blocked");
    a_rtc_pops: assert property (
        rtc_i && !call_i && !busy_o |=> stack_pop_o [*3])
        else $error("return pops");
    a_rtc_jump: assert property (
        rtc_i && !call_i && !busy_o |-> ##[4:5] pc_load_o)
        else $error("return jump");
endmodule // mem_ext_checker
bind paged_linear_memory_extender mem_ext_checker chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .cpu_addr_i(cpu_addr_i), .ext_addr_o(ext_addr_o),
    .win_hit_o(win_hit_o), .call_i(call_i), .rtc_i(rtc_i),
    .busy_o(busy_o), .ret_addr_i(ret_addr_i),
    .call_target_i(call_target_i), .stack_dout_o(stack_dout_o),
    .stack_push_o(stack_push_o), .stack_pop_o(stack_pop_o),
    .pc_load_o(pc_load_o), .pc_o(pc_o), .irq_block_o(irq_block_o));
`default_nettype wire

// >>> test/paged_linear_memory_extender_tb.sv
// self-checking bench for the paged linear memory extender
`timescale 1ns/1ps
`default_nettype none
module paged_linear_memory_extender_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0;
    logic stb_i = 1'b0, we_i = 1'b0, call_i = 1'b0, rtc_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [7:0] dat_i = 8'h00, call_page_i = 8'h00, q;
    logic [7:0] dat_o, stack_dout_o, stack_din_i;
    logic [15:0] cpu_addr_i = 16'h0000, call_target_i = 16'h0000;
    logic [15:0] ret_addr_i = 16'h0000, pc_o;
    logic [16:0] ext_addr_o;
    logic ack_o, win_hit_o, stack_push_o, stack_pop_o, pc_load_o;
    logic irq_block_o, busy_o;
    int errors = 0, num_checks = 0;
    paged_linear_memory_extender DUT (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .cpu_addr_i(cpu_addr_i), .call_i(call_i), .rtc_i(rtc_i),
        .call_page_i(call_page_i), .call_target_i(call_target_i),
        .ret_addr_i(ret_addr_i), .stack_din_i(stack_din_i),
        .ext_addr_o(ext_addr_o), .win_hit_o(win_hit_o),
        .stack_dout_o(stack_dout_o), .stack_push_o(stack_push_o),
        .stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
        .irq_block_o(irq_block_o), .busy_o(busy_o));
    cpu_stack_model STK (.clk_i(clk_i), .push_i(stack_push_o),
        .pop_i(stack_pop_o), .dout_i(stack_dout_o), .din_o(stack_din_i));
    initial forever #50 clk_i = ~clk_i;
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [16:0] got, input logic [16:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle; request held until ack is sampled high
    task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            errors++;
            final_report();
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task rdc(input logic [3:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk({9'h000, q}, {9'h000, e});
    endtask
    task rdp(input logic [16:0] e);
        logic [16:0] r;
        wb(1'b0, 4'h1, 8'h00);
        r[16] = q[0];
        wb(1'b0, 4'h2, 8'h00);
        r[15:8] = q;
        wb(1'b0, 4'h3, 8'h00);
        r[7:0] = q;
        chk(r, e);
    endtask
    task t_ptr;
        rdc(4'h0, 8'h02);
        wb(1'b1, 4'h1, 8'h01);
        wb(1'b1, 4'h2, 8'hFF);
        wb(1'b1, 4'h3, 8'hFE);
        rdp(17'h1FFFE);
        wb(1'b1, 4'h4, 8'h11);
        wb(1'b1, 4'h5, 8'h22);
        rdp(17'h00000);
        wb(1'b1, 4'h7, 8'hFE);
        rdp(17'h1FFFE);
        rdc(4'h6, 8'h11);
        rdp(17'h1FFFE);
        rdc(4'h5, 8'h11);
        rdc(4'h4, 8'h22);
        rdp(17'h00000);
        wb(1'b1, 4'h6, 8'h33);
        rdp(17'h00000);
        rdc(4'h6, 8'h33);
        wb(1'b1, 4'h7, 8'h7F);
        rdp(17'h0007F);
        wb(1'b1, 4'h7, 8'h80);
        rdp(17'h1FFFF);
        rdc(4'hF, 8'h00);
        $display("pointer test done");
    endtask
    task xl(input logic [15:0] a, input logic [16:0] e);
        @(posedge clk_i);
        cpu_addr_i <= a;
        @(posedge clk_i);
        @(negedge clk_i);
        chk(ext_addr_o, e);
    endtask
    task t_window;
        wb(1'b1, 4'h0, 8'h01);
        xl(16'h8000, 17'h04000);
        xl(16'h4000, 17'h04000);
        wb(1'b1, 4'h0, 8'h05);
        xl(16'hBFFF, 17'h17FFF);
        xl(16'hC000, 17'h0C000);
        wb(1'b1, 4'h7, 8'h01);
        rdc(4'h6, 8'h33);
        wb(1'b1, 4'h0, 8'h02);
        $display("window test done");
    endtask
    task wpc(input logic [15:0] e);
        int n;
        for (n = 0; n < 20 && pc_load_o !== 1'b1; n++)
            @(negedge clk_i);
        if (pc_load_o !== 1'b1) begin
            errors++;
            final_report();
        end
        chk({1'b0, pc_o}, {1'b0, e});
    endtask
    // page changes only through call and return from here on
    task t_call;
        @(posedge clk_i);
        call_page_i <= 8'h05;
        call_target_i <= 16'h8800;
        ret_addr_i <= 16'h1234;
        call_i <= 1'b1;
        @(posedge clk_i);
        call_i <= 1'b0;
        wpc(16'h8800);
        rdc(4'h0, 8'h05);
        @(posedge clk_i);
        rtc_i <= 1'b1;
        @(posedge clk_i);
        rtc_i <= 1'b0;
        wpc(16'h1234);
        rdc(4'h0, 8'h02);
        $display("call test done");
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_ptr();
        t_window();
        t_call();
        final_report();
    end
endmodule // paged_linear_memory_extender_tb
`default_nettype wire
